//--- common/lsd_pkg.sv
package lsd_pkg;

   // ----------------------------------------------------------------
   // channel, gain and bit queue sizes
   // ----------------------------------------------------------------
   localparam int CHANNELS   = 16;
   localparam int GAIN_BITS  = 8;    // 256 gain steps
   localparam int FIFO_WIDTH = 1;
   localparam int FIFO_DEPTH = 32;

   // ----------------------------------------------------------------
   // pin synchroniser layout: one vector, one bit per pin
   // ----------------------------------------------------------------
   localparam int PIN_SCLK   = 0;
   localparam int PIN_SIN    = 1;
   localparam int PIN_STROBE = 2;
   localparam int PIN_BLANK  = 3;
   localparam int PIN_OTEMP  = 4;
   localparam int PIN_OPEN   = 5;
   localparam int PIN_SHORT  = PIN_OPEN + CHANNELS;
   localparam int PIN_COUNT  = PIN_SHORT + CHANNELS;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   // idle levels: strobe pulled low, blank pulled high, the rest low
   localparam logic [PIN_COUNT-1:0] PIN_IDLE     = 37'h00_0000_0008;
   localparam logic [GAIN_BITS-1:0] GAIN_RESET   = 8'hff;
   localparam logic [CHANNELS-1:0]  CHAN_RESET   = 16'h0000;

   // ----------------------------------------------------------------
   // timing: fastest serial clock the block is built for
   // ----------------------------------------------------------------
   localparam int SCLK_MAX_MHZ    = 30;
   localparam int CLK_PERIOD_PS   = 8000;
   localparam int SCLK_PERIOD_PS  = 1000000 / SCLK_MAX_MHZ;
   // shortest serial period in system cycles, rounded down
   localparam int SCLK_MIN_CYCLES = SCLK_PERIOD_PS / CLK_PERIOD_PS;

endpackage

//--- logic/lsd_fifo.sv
module lsd_fifo
   import lsd_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
         $error("fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // ----------------------------------------------------------------
   // flags and handshakes
   // ----------------------------------------------------------------
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage has no reset: only words below the count are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

//--- logic/lsd_top.sv
module lsd_top
   import lsd_pkg::*;
(
   input  wire logic                 CLK,
   input  wire logic                 NRST,
   input  wire logic                 SERIAL_CLK,
   input  wire logic                 SERIAL_IN,
   input  wire logic                 LATCH_STROBE_MODE_SEL_A,
   input  wire logic                 BLANK_N_MODE_SEL_B,
   input  wire logic                 OVERTEMP,
   input  wire logic [CHANNELS-1:0]  OPEN_FAULT,
   input  wire logic [CHANNELS-1:0]  SHORT_FAULT,
   output logic      [CHANNELS-1:0]  SINK_OUTPUTS,
   output logic                      SERIAL_OUT,
   output logic      [GAIN_BITS-1:0] CURRENT_GAIN,
   output logic      [CHANNELS-1:0]  ERROR_BITS,
   output logic                      THERMAL_OFF,
   output logic                      SHIFT_OVERRUN
);

   initial begin
      if (SCLK_MIN_CYCLES < 2)
         $error("system clock too slow to sample the serial clock");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [PIN_COUNT-1:0] pins;
   logic [PIN_COUNT-1:0] s1_q;
   logic [PIN_COUNT-1:0] s2_q;
   logic [PIN_COUNT-1:0] s3_q;
   logic [PIN_COUNT-1:0] flt_q;
   logic [PIN_COUNT-1:0] flt_prev_q;

   assign pins = {SHORT_FAULT, OPEN_FAULT, OVERTEMP, BLANK_N_MODE_SEL_B,
                  LATCH_STROBE_MODE_SEL_A, SERIAL_IN, SERIAL_CLK};

   // idle levels stand in for the pull resistors until pins are driven
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a level counts once the second and third stages agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_filt
         always_ff @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
               flt_q[gi]      <= PIN_IDLE[gi];
               flt_prev_q[gi] <= PIN_IDLE[gi];
            end else begin
               flt_prev_q[gi] <= flt_q[gi];
               if (s2_q[gi] == s3_q[gi]) flt_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // filtered pin views and edge decode
   // ----------------------------------------------------------------
   function automatic logic rising(input logic now, input logic prev);
      return now & ~prev;
   endfunction

   wire                sclk_rise  = rising(flt_q[PIN_SCLK], flt_prev_q[PIN_SCLK]);
   // data bit as it stood before the clock edge, for setup margin
   wire                sin_bit    = flt_prev_q[PIN_SIN];
   wire                strobe     = flt_q[PIN_STROBE];
   wire                strobe_fall = rising(flt_prev_q[PIN_STROBE], flt_q[PIN_STROBE]);
   wire                blank_n    = flt_q[PIN_BLANK];
   wire                otemp      = flt_q[PIN_OTEMP];
   wire [CHANNELS-1:0] open_f     = flt_q[PIN_OPEN +: CHANNELS];
   wire [CHANNELS-1:0] short_f    = flt_q[PIN_SHORT +: CHANNELS];

   // mode select: strobe high at a serial edge makes it a command edge
   wire                mode_edge  = sclk_rise & strobe;
   wire                err_cmd    = mode_edge & ~blank_n;
   wire                gain_cmd   = mode_edge & blank_n;
   wire                data_edge  = sclk_rise & ~strobe;

   // ----------------------------------------------------------------
   // bit queue between pin sampling and the shift register
   // ----------------------------------------------------------------
   logic                  q_in_ready;
   logic                  q_out_valid;
   logic                  q_out_ready;
   logic [FIFO_WIDTH-1:0] q_out_data;
   logic                  err_pend_q;
   logic                  err_load;

   // error word waits until queued data has drained, keeping bit order
   assign err_load    = err_pend_q & ~q_out_valid;
   assign q_out_ready = ~err_load;

   lsd_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_queue (
      .clk       (CLK),
      .nrst      (NRST),
      .in_valid  (data_edge),
      .in_ready  (q_in_ready),
      .in_data   (sin_bit),
      .out_valid (q_out_valid),
      .out_ready (q_out_ready),
      .out_data  (q_out_data)
   );

   wire shift_en = q_out_valid & q_out_ready;

   // ----------------------------------------------------------------
   // shift register and error register
   // ----------------------------------------------------------------
   logic [CHANNELS-1:0] shift_q;
   logic [CHANNELS-1:0] err_q;

   // open and short faults land in the same channel bit
   wire  [CHANNELS-1:0] fault_now = open_f | short_f;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         shift_q <= CHAN_RESET;
      end else if (err_load) begin
         shift_q <= err_q;             // error word goes out the chain
      end else if (shift_en) begin
         shift_q <= {shift_q[CHANNELS-2:0], q_out_data[0]};
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         err_q      <= CHAN_RESET;
         err_pend_q <= 1'b0;
      end else begin
         if (err_cmd) err_q <= fault_now;
         if (err_cmd) err_pend_q <= 1'b1;
         else if (err_load) err_pend_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // output latches and gain register
   // ----------------------------------------------------------------
   logic [CHANNELS-1:0]  latch_q;
   logic [GAIN_BITS-1:0] gain_q;
   logic                 cap_pend_q;
   logic                 gain_arm_q;

   // capture is held off until queued bits are in the shift register
   wire follow   = (strobe | cap_pend_q) & ~gain_arm_q;
   wire cap_done = cap_pend_q & ~q_out_valid;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         latch_q <= CHAN_RESET;
      end else if (follow) begin
         latch_q <= shift_q;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cap_pend_q <= 1'b0;
      end else if (strobe_fall & ~gain_arm_q) begin
         cap_pend_q <= 1'b1;
      end else if (cap_done | strobe) begin
         cap_pend_q <= 1'b0;
      end
   end

   // gain command arms; the next strobe fall loads the low byte
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         gain_arm_q <= 1'b0;
         gain_q     <= GAIN_RESET;
      end else begin
         if (gain_cmd) begin
            gain_arm_q <= 1'b1;
         end else if (strobe_fall & ~q_out_valid) begin
            gain_arm_q <= 1'b0;
         end
         if (gain_arm_q & strobe_fall & ~q_out_valid)
            gain_q <= shift_q[GAIN_BITS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   // overtemperature shuts all sinks as the blank pin would
   wire                sinks_on  = ~blank_n & ~otemp;
   wire [CHANNELS-1:0] sink_d    = sinks_on ? latch_q : CHAN_RESET;
   logic               overrun_q;

   // overrun is sticky: a lost edge corrupts the whole chain
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         overrun_q <= 1'b0;
      end else if (data_edge & ~q_in_ready) begin
         overrun_q <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         SINK_OUTPUTS  <= CHAN_RESET;
         SERIAL_OUT    <= 1'b0;
         CURRENT_GAIN  <= GAIN_RESET;
         ERROR_BITS    <= CHAN_RESET;
         THERMAL_OFF   <= 1'b0;
         SHIFT_OVERRUN <= 1'b0;
      end else begin
         SINK_OUTPUTS  <= sink_d;
         SERIAL_OUT    <= shift_q[CHANNELS-1];
         CURRENT_GAIN  <= gain_q;
         ERROR_BITS    <= err_q;
         THERMAL_OFF   <= otemp;
         SHIFT_OVERRUN <= overrun_q;
      end
   end

endmodule

//--- test/lsd_chk.sv
module lsd_chk
   import lsd_pkg::*;
(
   input wire logic                 CLK,
   input wire logic                 NRST,
   input wire logic                 SERIAL_CLK,
   input wire logic                 SERIAL_IN,
   input wire logic                 LATCH_STROBE_MODE_SEL_A,
   input wire logic                 BLANK_N_MODE_SEL_B,
   input wire logic                 OVERTEMP,
   input wire logic [CHANNELS-1:0]  OPEN_FAULT,
   input wire logic [CHANNELS-1:0]  SHORT_FAULT,
   input wire logic [CHANNELS-1:0]  SINK_OUTPUTS,
   input wire logic                 SERIAL_OUT,
   input wire logic [GAIN_BITS-1:0] CURRENT_GAIN,
   input wire logic [CHANNELS-1:0]  ERROR_BITS,
   input wire logic                 THERMAL_OFF,
   input wire logic                 SHIFT_OVERRUN
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // helper ages
   // ------------------------------------------------------------
   logic       sclk_q;
   logic       stb_q;
   logic [3:0] sclk_age_q;
   logic [3:0] sclk_age_d;
   logic [3:0] stb_age_q;
   logic [3:0] stb_age_d;

   // cycles since serial clock rose or strobe fell; saturate so no wrap aliasing
   assign sclk_age_d = (SERIAL_CLK && !sclk_q) ? 4'h0 : sclk_age_q + {3'h0, sclk_age_q != 4'hf};
   assign stb_age_d  = (stb_q && !LATCH_STROBE_MODE_SEL_A) ? 4'h0 :
                       stb_age_q + {3'h0, stb_age_q != 4'hf};

   // edge memories
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         {sclk_q, stb_q, sclk_age_q, stb_age_q} <= {2'h0, 8'hff};
      end else begin
         {sclk_q, stb_q} <= {SERIAL_CLK, LATCH_STROBE_MODE_SEL_A};
         {sclk_age_q, stb_age_q} <= {sclk_age_d, stb_age_d};
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   rst_vals_a: assert property ($rose(NRST) |->
      SINK_OUTPUTS == '0 && ERROR_BITS == '0 && CURRENT_GAIN == GAIN_RESET)
      else $error("outputs wrong after reset");
   blank_off_a: assert property (BLANK_N_MODE_SEL_B [*8] |-> SINK_OUTPUTS == '0)
      else $error("sinks on while blanked");
   therm_on_a: assert property (OVERTEMP [*8] |-> THERMAL_OFF)
      else $error("thermal flag missing");
   therm_clr_a: assert property (!OVERTEMP [*8] |-> !THERMAL_OFF)
      else $error("thermal flag stuck");
   therm_sink_a: assert property (THERMAL_OFF [*3] |-> SINK_OUTPUTS == '0)
      else $error("sinks on while hot");
   // filter plus queue put a shift about six cycles after the rise; a fall is later
   sout_cause_a: assert property ($changed(SERIAL_OUT) |-> sclk_age_q <= 4'ha)
      else $error("serial out moved without a rise");
   err_cause_a: assert property ($changed(ERROR_BITS) |->
      LATCH_STROBE_MODE_SEL_A && sclk_age_q <= 4'ha)
      else $error("error bits moved without command");
   gain_cause_a: assert property ($changed(CURRENT_GAIN) |->
      !LATCH_STROBE_MODE_SEL_A && stb_age_q <= 4'ha)
      else $error("gain moved without strobe fall");

   // overrun only clears by reset: a lost edge leaves the chain suspect
   ovr_sticky_a: assert property ($past(SHIFT_OVERRUN) |-> SHIFT_OVERRUN)
      else $error("overrun flag dropped");

   cover property ($changed(CURRENT_GAIN));
   cover property ($changed(ERROR_BITS));
   cover property ($rose(THERMAL_OFF));
endmodule

bind lsd_top lsd_chk u_lsd_chk (.CLK, .NRST, .SERIAL_CLK, .SERIAL_IN, .LATCH_STROBE_MODE_SEL_A,
   .BLANK_N_MODE_SEL_B, .OVERTEMP, .OPEN_FAULT, .SHORT_FAULT, .SINK_OUTPUTS, .SERIAL_OUT,
   .CURRENT_GAIN, .ERROR_BITS, .THERMAL_OFF, .SHIFT_OVERRUN);

//--- test/lsd_host.sv
module lsd_host
   import lsd_pkg::*;
(
   input  wire logic clk,
   input  wire logic sout,
   output logic      sclk,
   output logic      serial_in,
   output logic      strobe,
   output logic      blank_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // controller side of the serial link
   // ------------------------------------------------------------
   // clock stands low between frames
   initial begin
      {sclk, serial_in, strobe, blank_n} = 4'h1;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic set_blank(input logic b);
      blank_n = b;
      tick(1);
   endtask

   // 12 cycle bit: slow enough for the pin filter, far under the rate limit
   task automatic xfer(input logic [CHANNELS-1:0] w, output logic [CHANNELS-1:0] rd);
      for (int i = CHANNELS - 1; i >= 0; i--) begin
         rd[i] = sout;
         serial_in = w[i];
         tick(3);
         sclk = 1'b1;
         tick(6);
         sclk = 1'b0;
         tick(3);
      end
      serial_in = ~serial_in; // released line shows the inverse
      tick(1);
   endtask

   // strobe high then low: transparent, then capture
   task automatic latch();
      strobe = 1'b1;
      tick(10);
      strobe = 1'b0;
      tick(12);
   endtask

   // rise with strobe high picks a mode by blank level
   task automatic cmd(input logic b);
      {strobe, blank_n} = {1'b1, b};
      tick(6);
      sclk = 1'b1;
      tick(6);
      sclk = 1'b0;
      tick(6);
      strobe = 1'b0;
      tick(12);
   endtask
endmodule

//--- test/tb_top.sv
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin failures++; \
   $display("mismatch %s expected %h seen %h", nm, e, a); end end

module tb_top
   import lsd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [CHANNELS-1:0] word;
      logic                blank;
      logic [CHANNELS-1:0] sink;
   } lsd_row_t;

   localparam lsd_row_t ROWS [4] = '{'{16'ha5c3, 1'b0, 16'ha5c3}, '{16'hffff, 1'b1, 16'h0000},
                                     '{16'h0001, 1'b0, 16'h0001}, '{16'h8000, 1'b0, 16'h8000}};
   logic                 clk = 1'b0;
   logic                 nrst = 1'b0;
   logic                 ot = 1'b0;
   logic [CHANNELS-1:0]  open_f = '0;
   logic [CHANNELS-1:0]  short_f = '0;
   logic [CHANNELS-1:0]  rd;
   logic                 sclk, serial_in, stb, blank_n, sout, toff, ovr;
   logic [CHANNELS-1:0]  sink, err;
   logic [GAIN_BITS-1:0] gain;
   int                   failures = 0;
   int                   compares = 0;

   always #4 clk = ~clk;

   lsd_host u_lsd_host (.clk(clk), .sout(sout), .sclk(sclk), .serial_in(serial_in), .strobe(stb),
                        .blank_n(blank_n));
   lsd_top u_lsd_top (.CLK(clk), .NRST(nrst), .SERIAL_CLK(sclk), .SERIAL_IN(serial_in),
      .LATCH_STROBE_MODE_SEL_A(stb), .BLANK_N_MODE_SEL_B(blank_n), .OVERTEMP(ot),
      .OPEN_FAULT(open_f), .SHORT_FAULT(short_f), .SINK_OUTPUTS(sink), .SERIAL_OUT(sout),
      .CURRENT_GAIN(gain), .ERROR_BITS(err), .THERMAL_OFF(toff), .SHIFT_OVERRUN(ovr));

   task automatic close_out();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      u_lsd_host.tick(10);
      nrst = 1'b1;
      u_lsd_host.tick(1);
      `CHK("gain", GAIN_RESET, gain)
      `CHK("sink", 16'h0000, sink)
      u_lsd_host.set_blank(1'b0);
      u_lsd_host.xfer(16'h1234, rd);
      `CHK("sink", 16'h0000, sink)
      // each row: load, latch, then shift a new word that must not leak out
      for (int i = 0; i < 4; i++) begin
         u_lsd_host.set_blank(ROWS[i].blank);
         u_lsd_host.xfer(ROWS[i].word, rd);
         u_lsd_host.latch();
         `CHK("sink", ROWS[i].sink, sink)
         `CHK("sout", ROWS[i].word[15], sout)
         u_lsd_host.xfer(~ROWS[i].word, rd);
         `CHK("hold", ROWS[i].sink, sink)
         `CHK("readback", ROWS[i].word, rd)
      end
      // open and short share bit 8, one register bit each channel
      open_f = 16'h0f00;
      short_f = 16'h0103;
      u_lsd_host.cmd(1'b0);
      `CHK("errbits", 16'h0f03, err)
      u_lsd_host.xfer(16'h0000, rd);
      `CHK("errread", 16'h0f03, rd)
      u_lsd_host.xfer(16'h005a, rd);
      u_lsd_host.cmd(1'b1);
      `CHK("gain", 8'h5a, gain)
      u_lsd_host.set_blank(1'b0);
      u_lsd_host.xfer(16'h00ff, rd);
      u_lsd_host.latch();
      ot = 1'b1;
      u_lsd_host.tick(12);
      `CHK("thermal", 1'b1, toff)
      `CHK("sink", 16'h0000, sink)
      ot = 1'b0;
      u_lsd_host.tick(12);
      `CHK("sink", 16'h00ff, sink)
      `CHK("overrun", 1'b0, ovr)
      nrst = 1'b0;
      u_lsd_host.tick(3);
      nrst = 1'b1;
      u_lsd_host.tick(1);
      `CHK("gain", GAIN_RESET, gain)
      `CHK("errbits", 16'h0000, err)
      close_out();
   end

   // run needs about 2500 cycles; eight times that means a hang
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      close_out();
   end
endmodule
